// ==== rtl/flow_control_consts.vh ====
`ifndef FLOW_CONTROL_CONSTS_VH
`define FLOW_CONTROL_CONSTS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define FC_ADDR_W            12
`define FC_PORT1_OFFSET      12'h1A0
`define FC_RESERVED_FILL     25'h0000000

// ----------------------------------------------------------------
// Field positions of the port 1 flow control register
// ----------------------------------------------------------------
`define FC_BIT_MANUAL_SEL    0
`define FC_BIT_TX_PAUSE      1
`define FC_BIT_RX_PAUSE      2
`define FC_BIT_CUR_TX        3
`define FC_BIT_CUR_RX        4
`define FC_BIT_CUR_DUPLEX    5
`define FC_BIT_BACKPRESSURE  6

// ----------------------------------------------------------------
// Reset values before the straps are captured
// ----------------------------------------------------------------
`define FC_RST_BIT           1'b0
`define FC_RST_STRAPS        3'h0
`define FC_RST_READDATA      32'h00000000
`define FC_UNMAPPED_DATA     32'h00000000

// ----------------------------------------------------------------
// Port 1 operating modes
// ----------------------------------------------------------------
`define FC_MODE_INTERNAL_PHY 2'h0
`define FC_MODE_MII_PHY      2'h1
`define FC_MODE_RMII_PHY     2'h2
`define FC_MODE_MII_MAC      2'h3

// ----------------------------------------------------------------
// Strap vector layout
// ----------------------------------------------------------------
`define FC_STRAP_BP          0
`define FC_STRAP_FD_PAUSE    1
`define FC_STRAP_MANUAL      2
`define FC_STRAP_W           3

`endif

// ==== rtl/flow_resolve.v ====
`timescale 1ns/1ps

module flow_resolve (
  input  wire manual_select,
  input  wire autoneg_enable,
  input  wire full_duplex,
  input  wire manual_rx,
  input  wire manual_tx,
  input  wire an_rx,
  input  wire an_tx,
  output reg  rx_active,
  output reg  tx_active
);

  // ----------------------------------------------------------------
  // Pause only applies in full duplex
  // ----------------------------------------------------------------
  always @* begin
    rx_active = 1'b0;
    tx_active = 1'b0;
    if (full_duplex) begin
      if (manual_select || !autoneg_enable) begin
        rx_active = manual_rx;
        tx_active = manual_tx;
      end else begin
        rx_active = an_rx;
        tx_active = an_tx;
      end
    end
  end

endmodule // flow_resolve

// ==== rtl/port1_flow_control_config.v ====
// Operation
// - Bit 6 enables half-duplex backpressure on port 1.
// - Read-only bit 5 shows duplex in effect: 0 full, 1 half.
// - Read-only bit 4 shows receive pause currently active.
// - Read-only bit 3 shows transmit pause currently active.
// - Status bits follow the enabled flow control, manual or negotiated.
// - Bit 2 enables received pause detection when manual or autoneg off.
// - Bit 1 enables pause generation when manual or autoneg off.
// - Manual select 0 with autoneg on: negotiated result used, manual ignored.
// - Manual select 0 with autoneg off: manual enables applied.
// - Manual select 1: manual enables decide flow control in full duplex.
// - In MII PHY, RMII PHY, MII MAC modes manual select held at 1.
// - Manual select read-only in those modes, read-write otherwise.
// - In those modes manual select defaults 1, loader never overwrites it.
// - Otherwise manual select defaults from manual flow strap.
// - Backpressure enable defaults from backpressure strap latched at reset.
// - Manual pause enables default from full-duplex pause strap.
// - Status reset values derive from the combined straps.
// - Loader rewriting straps updates the strap-derived fields.
// - Writes do not change the PHY pause advertisement.
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "flow_control_consts.vh"

module port1_flow_control_config #(
  parameter ADDR_W = `FC_ADDR_W
) (
  input  wire              clk,
  input  wire              rst_n,
  input  wire [ADDR_W-1:0] address,
  input  wire              read,
  input  wire              write,
  input  wire [31:0]       writedata,
  input  wire [3:0]        byteenable,
  output reg  [31:0]       readdata,
  output reg               waitrequest,
  input  wire [1:0]        port_mode,
  input  wire              autoneg_enable,
  input  wire              link_full_duplex,
  input  wire              an_rx_pause,
  input  wire              an_tx_pause,
  input  wire              backpressure_strap,
  input  wire              full_duplex_pause_strap,
  input  wire              manual_flow_strap,
  input  wire              strap_reload,
  output reg               backpressure_enable,
  output reg               backpressure_active,
  output reg               rx_pause_enable,
  output reg               tx_pause_enable
);

  localparam ST_IDLE = 1'b0;
  localparam ST_ACK  = 1'b1;

  reg                   state_reg;
  reg                   state_next;
  reg                   manual_flow_select_reg;
  reg                   manual_rx_pause_enable_reg;
  reg                   manual_tx_pause_enable_reg;
  reg                   current_duplex_status_reg;
  reg                   current_rx_pause_status_reg;
  reg                   current_tx_pause_status_reg;
  reg  [31:0]           readdata_next;
  wire [`FC_STRAP_W-1:0] strap_bus;
  wire [`FC_STRAP_W-1:0] strap_value;
  wire                  strap_load;
  wire                  no_autoneg_mode;
  wire                  reg_hit;
  wire                  write_commit;
  wire                  rx_resolved;
  wire                  tx_resolved;
  wire [31:0]           reg_image;

  // ----------------------------------------------------------------
  // Strap capture and reload
  // ----------------------------------------------------------------
  assign strap_bus[`FC_STRAP_BP]       = backpressure_strap;
  assign strap_bus[`FC_STRAP_FD_PAUSE] = full_duplex_pause_strap;
  assign strap_bus[`FC_STRAP_MANUAL]   = manual_flow_strap;

  strap_capture #(
    .WIDTH (`FC_STRAP_W)
  ) u_strap_capture (
    .clk         (clk),
    .rst_n       (rst_n),
    .strap_in    (strap_bus),
    .reload      (strap_reload),
    .strap_value (strap_value),
    .strap_load  (strap_load)
  );

  assign no_autoneg_mode = (port_mode == `FC_MODE_MII_PHY) ||
                           (port_mode == `FC_MODE_RMII_PHY) ||
                           (port_mode == `FC_MODE_MII_MAC);

  // ----------------------------------------------------------------
  // Avalon slave handshake: one wait cycle, then acknowledge
  // ----------------------------------------------------------------
  assign reg_hit      = (address == `FC_PORT1_OFFSET);
  assign write_commit = (state_reg == ST_ACK) && write && reg_hit && byteenable[0];

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (read || write) begin
          state_next = ST_ACK;
        end
      end
      ST_ACK: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= ST_IDLE;
      waitrequest <= 1'b1;
      readdata    <= `FC_RST_READDATA;
    end else begin
      state_reg   <= state_next;
      waitrequest <= ~((state_reg == ST_IDLE) && (read || write));
      if ((state_reg == ST_IDLE) && read) begin
        readdata <= readdata_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read image
  // ----------------------------------------------------------------
  assign reg_image = {`FC_RESERVED_FILL,
                      backpressure_enable,
                      current_duplex_status_reg,
                      current_rx_pause_status_reg,
                      current_tx_pause_status_reg,
                      manual_rx_pause_enable_reg,
                      manual_tx_pause_enable_reg,
                      manual_flow_select_reg};

  always @* begin
    readdata_next = `FC_UNMAPPED_DATA;
    if (reg_hit) begin
      readdata_next = reg_image;
    end
  end

  // ----------------------------------------------------------------
  // Writable fields; the strap reload wins over a write in one cycle
  // Nothing here reaches the PHY advertisement register
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      backpressure_enable        <= `FC_RST_BIT;
      manual_rx_pause_enable_reg <= `FC_RST_BIT;
      manual_tx_pause_enable_reg <= `FC_RST_BIT;
      manual_flow_select_reg     <= `FC_RST_BIT;
    end else if (strap_load) begin
      backpressure_enable        <= strap_value[`FC_STRAP_BP];
      manual_rx_pause_enable_reg <= strap_value[`FC_STRAP_FD_PAUSE];
      manual_tx_pause_enable_reg <= strap_value[`FC_STRAP_FD_PAUSE];
      if (no_autoneg_mode) begin
        manual_flow_select_reg <= 1'b1;
      end else begin
        manual_flow_select_reg <= strap_value[`FC_STRAP_MANUAL];
      end
    end else begin
      if (write_commit) begin
        backpressure_enable        <= writedata[`FC_BIT_BACKPRESSURE];
        manual_rx_pause_enable_reg <= writedata[`FC_BIT_RX_PAUSE];
        manual_tx_pause_enable_reg <= writedata[`FC_BIT_TX_PAUSE];
      end
      if (no_autoneg_mode) begin
        manual_flow_select_reg <= 1'b1;
      end else if (write_commit) begin
        manual_flow_select_reg <= writedata[`FC_BIT_MANUAL_SEL];
      end
    end
  end

  // ----------------------------------------------------------------
  // Flow control in effect and its status
  // ----------------------------------------------------------------
  flow_resolve u_flow_resolve (
    .manual_select  (manual_flow_select_reg),
    .autoneg_enable (autoneg_enable & ~no_autoneg_mode),
    .full_duplex    (link_full_duplex),
    .manual_rx      (manual_rx_pause_enable_reg),
    .manual_tx      (manual_tx_pause_enable_reg),
    .an_rx          (an_rx_pause),
    .an_tx          (an_tx_pause),
    .rx_active      (rx_resolved),
    .tx_active      (tx_resolved)
  );

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      current_duplex_status_reg   <= `FC_RST_BIT;
      current_rx_pause_status_reg <= `FC_RST_BIT;
      current_tx_pause_status_reg <= `FC_RST_BIT;
      rx_pause_enable             <= `FC_RST_BIT;
      tx_pause_enable             <= `FC_RST_BIT;
      backpressure_active         <= `FC_RST_BIT;
    end else begin
      current_duplex_status_reg   <= ~link_full_duplex;
      current_rx_pause_status_reg <= rx_resolved;
      current_tx_pause_status_reg <= tx_resolved;
      rx_pause_enable             <= rx_resolved;
      tx_pause_enable             <= tx_resolved;
      backpressure_active         <= backpressure_enable & ~link_full_duplex;
    end
  end

endmodule // port1_flow_control_config

// ==== rtl/strap_capture.v ====
`timescale 1ns/1ps
`include "flow_control_consts.vh"

module strap_capture #(
  parameter WIDTH = `FC_STRAP_W
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] strap_in,
  input  wire             reload,
  output reg  [WIDTH-1:0] strap_value,
  output reg              strap_load
);

  reg armed_reg;

  // ----------------------------------------------------------------
  // Capture at the first edge after reset release and on each reload
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_reg   <= 1'b0;
      strap_value <= {WIDTH{1'b0}};
      strap_load  <= 1'b0;
    end else begin
      armed_reg  <= 1'b1;
      strap_load <= 1'b0;
      if (!armed_reg || reload) begin
        strap_value <= strap_in;
        strap_load  <= 1'b1;
      end
    end
  end

endmodule // strap_capture

// ==== verification/flow_checker_asserts.sv ====
`timescale 1ns/1ps
`include "flow_control_consts.vh"
// ------------------------------------------------------------
// Port 1 flow control checks
// ------------------------------------------------------------
module flow_checker #(
  parameter ADDR_W = `FC_ADDR_W
) (
  input wire              clk,
  input wire              rst_n,
  input wire [ADDR_W-1:0] address,
  input wire              read,
  input wire              write,
  input wire [31:0]       readdata,
  input wire              waitrequest,
  input wire [1:0]        port_mode,
  input wire              link_full_duplex,
  input wire              strap_reload,
  input wire              backpressure_enable,
  input wire              backpressure_active,
  input wire              rx_pause_enable,
  input wire              tx_pause_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ack_one; !waitrequest |=> waitrequest; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held too long");
  property p_ack_soon; (read || write) && waitrequest |-> ##[1:2] !waitrequest; endproperty
  a_ack_soon: assert property (p_ack_soon) else $error("request not answered");
  property p_reserved; $fell(waitrequest) && $past(read) |-> readdata[31:7] == 25'h0; endproperty
  a_reserved: assert property (p_reserved) else $error("upper bits not zero");
  property p_unmapped;
    $fell(waitrequest) && $past(read) && $past(address) != `FC_PORT1_OFFSET |-> readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_bp_read;
    $fell(waitrequest) && $past(read) && $past(address) == `FC_PORT1_OFFSET &&
    $stable(backpressure_enable) && !$past(strap_reload) && !$past(strap_reload, 2) &&
    !$past(strap_reload, 3) |-> readdata[6] == backpressure_enable;
  endproperty
  a_bp_read: assert property (p_bp_read) else $error("bit 6 differs from output");
  property p_half_pause; (!link_full_duplex)[*2] |=> !rx_pause_enable && !tx_pause_enable; endproperty
  a_half_pause: assert property (p_half_pause) else $error("pause in half duplex");
  property p_bp_on; (backpressure_enable && !link_full_duplex)[*2] |=> backpressure_active; endproperty
  a_bp_on: assert property (p_bp_on) else $error("backpressure not active");
  property p_bp_off; (!backpressure_enable || link_full_duplex)[*2] |=> !backpressure_active; endproperty
  a_bp_off: assert property (p_bp_off) else $error("backpressure wrongly active");
  property p_forced;
    $fell(waitrequest) && $past(read) && $past(address) == `FC_PORT1_OFFSET &&
    $past(port_mode) != 2'h0 && $past(port_mode, 2) != 2'h0 |-> readdata[0];
  endproperty
  a_forced: assert property (p_forced) else $error("manual select not forced");
  c_write: cover property ($fell(waitrequest) && $past(write));
  c_bp: cover property (backpressure_active);
  c_reload: cover property (strap_reload);
endmodule // flow_checker

bind port1_flow_control_config flow_checker #(.ADDR_W(ADDR_W)) u_chk (
  .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .port_mode(port_mode),
  .link_full_duplex(link_full_duplex), .strap_reload(strap_reload),
  .backpressure_enable(backpressure_enable), .backpressure_active(backpressure_active),
  .rx_pause_enable(rx_pause_enable), .tx_pause_enable(tx_pause_enable));

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`include "flow_control_consts.vh"
module testbench;
  localparam [11:0] OFF = `FC_PORT1_OFFSET;
  logic        clk, rst_n, read, write, an_en, fdx, an_rx, an_tx, bp_s, fd_s, man_s, reload;
  logic [11:0] address;
  logic [31:0] writedata, readdata, rdata;
  logic [3:0]  byteenable;
  logic [1:0]  port_mode;
  logic        waitrequest, bp_en, bp_act, rx_en, tx_en;
  int          n_errors, checked;
  port1_flow_control_config dut (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .port_mode(port_mode), .autoneg_enable(an_en),
    .link_full_duplex(fdx), .an_rx_pause(an_rx), .an_tx_pause(an_tx),
    .backpressure_strap(bp_s), .full_duplex_pause_strap(fd_s), .manual_flow_strap(man_s),
    .strap_reload(reload), .backpressure_enable(bp_en), .backpressure_active(bp_act),
    .rx_pause_enable(rx_en), .tx_pause_enable(tx_en));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic end_of_test();
    if (n_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    read <= !w; write <= w; address <= a; writedata <= d; byteenable <= be;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20) check("waitrequest", waitrequest, 32'h0);
    rdata = readdata;
    read <= 1'b0; write <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hF);
    check("readdata", rdata, exp);
    if (a == OFF) check("pause outputs", {30'h0, rx_en, tx_en}, {30'h0, exp[4:3]});
  endtask
  task automatic wr_chk(input logic [31:0] d, input logic [31:0] exp);
    bus(1'b1, OFF, d, 4'hF);
    rd_chk(OFF, exp);
  endtask
  task automatic pulse_reload();
    @(posedge clk); reload <= 1'b1;
    @(posedge clk); reload <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_defaults(); rd_chk(OFF, 32'h4E); endtask
  task automatic t_manual(); wr_chk(32'hFFFFFFBD, 32'h15); endtask
  task automatic t_autoneg();
    an_en <= 1'b0;
    wr_chk(32'h02, 32'h0A);
    an_en <= 1'b1; an_rx <= 1'b1; an_tx <= 1'b0;
    rd_chk(OFF, 32'h12);
  endtask
  task automatic t_half();
    fdx <= 1'b0;
    wr_chk(32'h47, 32'h67);
    check("bp outputs", {30'h0, bp_en, bp_act}, 32'h3);
  endtask
  task automatic t_refused();
    fdx <= 1'b1;
    bus(1'b1, OFF, 32'h0, 4'h0);
    bus(1'b1, 12'h1A4, 32'h0, 4'hF);
    rd_chk(OFF, 32'h5F);
    rd_chk(12'h1A4, 32'h0);
  endtask
  task automatic t_modes();
    for (int m = 1; m < 4; m++) begin
      port_mode <= m[1:0];
      wr_chk(32'h00, 32'h01);
      wr_chk(32'h06, 32'h1F);
    end
  endtask
  task automatic t_reload();
    bp_s <= 1'b0; fd_s <= 1'b0; man_s <= 1'b0;
    pulse_reload();
    rd_chk(OFF, 32'h01);
    port_mode <= 2'h0; bp_s <= 1'b1; fd_s <= 1'b1;
    pulse_reload();
    rd_chk(OFF, 32'h56);
  endtask
  // ------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0; read = 1'b0; write = 1'b0; address = 12'h0; writedata = 32'h0;
    byteenable = 4'hF; port_mode = 2'h0; an_en = 1'b1; fdx = 1'b1; an_rx = 1'b0;
    an_tx = 1'b1; bp_s = 1'b1; fd_s = 1'b1; man_s = 1'b0; reload = 1'b0;
    n_errors = 0; checked = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    t_defaults(); t_manual(); t_autoneg(); t_half(); t_refused(); t_modes(); t_reload();
    end_of_test();
  end
  initial begin
    #40000;
    n_errors++;
    end_of_test();
  end
endmodule // testbench
